/* hdl/smbus_alert_pkg.sv */
// What this block does
// - Three three-state pins select one of 27 addresses.
// - Address top two bits fixed at binary 10.
// - Broadcast write address 1011111 is also accepted.
// - Broadcast write ignored when enable bit is zero.
// - Alert response address acknowledged only while alerting.
// - Transmitter releases data; receiver holds ack low.
// - Acked command byte loads low three pointer bits.
// - First write data byte acked and stored.
// - Second write data byte acked and discarded.
// - Read uses repeated START; device returns register.
// - Master ack repeats the same register byte.
// - Pointer keeps its value between transactions.
// - Enabled logged fault pulls alert line low.
// - Alert responders send address; losers drop out.
// - Arbitration winner releases alert; losers keep it.
// - Individual addressing releases the alert line.
// - No new alert until different or recurring fault.
// - Data line split into input and open-drain output.
// - Upper five command bits ignored for decoding.
package smbus_alert_pkg;

	localparam logic [1:0] ADDR_FIXED_MSB = 2'h2;
	localparam logic [6:0] BCAST_ADDR = 7'h5f;
	localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;
	localparam int PTR_W = 3;
	localparam logic [PTR_W-1:0] PTR_RESET = 3'h0;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam logic [1:0] PIN_LOW = 2'h0;
	localparam logic [1:0] PIN_HIGH = 2'h1;
	localparam logic [1:0] PIN_OPEN = 2'h2;
	localparam int PIN_STATES = 3;

	localparam int CLK_PERIOD_PS = 8000;
	localparam int SPIKE_FILT_NS = 16;
	// Longest tolerated spike, so the cycle count rounds down.
	localparam int SPIKE_FILT_CYC = (SPIKE_FILT_NS * 1000 / CLK_PERIOD_PS) < 1 ?
		1 : (SPIKE_FILT_NS * 1000 / CLK_PERIOD_PS);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RX,
		ST_ACK,
		ST_TX,
		ST_MACK
	} bus_state_t;

	typedef enum logic [1:0] {
		K_ADDR,
		K_CMD,
		K_DATA,
		K_EXTRA
	} byte_kind_t;

	// Low five address bits for a pin state index of pin2*9+pin1*3+pin0.
	function automatic logic [4:0] addr_low_bits(input logic [4:0] idx);
		logic [4:0] v;
		v = 5'h00;
		unique case (idx)
			5'h00: v = 5'h04;
			5'h01: v = 5'h07;
			5'h02: v = 5'h06;
			5'h03: v = 5'h18;
			5'h04: v = 5'h05;
			5'h05: v = 5'h01;
			5'h06: v = 5'h00;
			5'h07: v = 5'h03;
			5'h08: v = 5'h02;
			5'h09: v = 5'h14;
			5'h0a: v = 5'h17;
			5'h0b: v = 5'h16;
			5'h0c: v = 5'h1a;
			5'h0d: v = 5'h15;
			5'h0e: v = 5'h11;
			5'h0f: v = 5'h10;
			5'h10: v = 5'h13;
			5'h11: v = 5'h12;
			5'h12: v = 5'h0c;
			5'h13: v = 5'h0f;
			5'h14: v = 5'h0e;
			5'h15: v = 5'h19;
			5'h16: v = 5'h0d;
			5'h17: v = 5'h09;
			5'h18: v = 5'h08;
			5'h19: v = 5'h0b;
			5'h1a: v = 5'h0a;
			default: v = 5'h00;
		endcase
		return v;
	endfunction : addr_low_bits

endpackage : smbus_alert_pkg

/* hdl/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync
	import smbus_alert_pkg::*;
#(
	parameter int WIDTH = 2,
	parameter logic [WIDTH-1:0] RESET_VAL = '1,
	parameter int FILT_CYC = 1
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	// Pins
	input wire logic [WIDTH-1:0] i_async,
	// Filtered levels
	output logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] stab_r;

	// The first flop feeds only the second, so no logic sees metastability.
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			meta_r <= RESET_VAL;
			stab_r <= RESET_VAL;
		end else begin
			meta_r <= i_async;
			stab_r <= meta_r;
		end
	end

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_filt
			logic [7:0] cnt_r;
			logic [7:0] cnt_nxt;
			logic out_r;
			logic out_nxt;
			// A change must hold for FILT_CYC cycles before it is passed on.
			always_comb begin
				cnt_nxt = 8'h00;
				out_nxt = out_r;
				if (stab_r[g] != out_r) begin
					if (cnt_r >= 8'(FILT_CYC - 1)) begin
						out_nxt = stab_r[g];
					end else begin
						cnt_nxt = cnt_r + 8'h01;
					end
				end
			end
			always_ff @(posedge i_clk_sys or negedge i_nrst) begin
				if (!i_nrst) begin
					cnt_r <= 8'h00;
					out_r <= RESET_VAL[g];
				end else begin
					cnt_r <= cnt_nxt;
					out_r <= out_nxt;
				end
			end
			assign o_sync[g] = out_r;
		end
	endgenerate

endmodule : pin_sync

/* hdl/smbus_slave_alert.sv */
`timescale 1ns/1ps
module smbus_slave_alert
	import smbus_alert_pkg::*;
#(
	parameter int N_FAULT = 8
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	// Two-wire bus
	input wire logic i_scl,
	input wire logic i_serial_data_in_line,
	output logic o_serial_data_out_line,
	output logic o_serial_data_out_line_oe,
	// Alert line, open drain
	output logic o_alert_out,
	output logic o_alert_oe,
	// Address select pins, three-state each
	input wire logic [2:0] i_addr_select_pins_high,
	input wire logic [2:0] i_addr_select_pins_open,
	// Control and fault state from the register file
	input wire logic i_broadcast_write_enable_bit,
	input wire logic [N_FAULT-1:0] i_fault_log,
	input wire logic [N_FAULT-1:0] i_alert_enable,
	// Register access
	output logic [PTR_W-1:0] o_reg_ptr,
	input wire logic [7:0] i_reg_rd_data,
	output logic o_reg_wr_stb,
	output logic [7:0] o_reg_wr_data
);

	logic scl_s;
	logic sda_s;
	logic [2:0] pin_hi_s;
	logic [2:0] pin_open_s;

	pin_sync #(
		.WIDTH(2),
		.RESET_VAL(2'h3),
		.FILT_CYC(SPIKE_FILT_CYC)
	) u_bus_sync (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_async({i_scl, i_serial_data_in_line}),
		.o_sync({scl_s, sda_s})
	);

	pin_sync #(
		.WIDTH(6),
		.RESET_VAL(6'h00),
		.FILT_CYC(1)
	) u_pin_sync (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_async({i_addr_select_pins_high, i_addr_select_pins_open}),
		.o_sync({pin_hi_s, pin_open_s})
	);

	logic scl_d_r;
	logic sda_d_r;
	logic [6:0] own_addr_r;
	logic [6:0] own_addr_nxt;

	always_comb begin
		logic [1:0] c0;
		logic [1:0] c1;
		logic [1:0] c2;
		logic [4:0] idx;
		c0 = pin_open_s[0] ? PIN_OPEN : (pin_hi_s[0] ? PIN_HIGH : PIN_LOW);
		c1 = pin_open_s[1] ? PIN_OPEN : (pin_hi_s[1] ? PIN_HIGH : PIN_LOW);
		c2 = pin_open_s[2] ? PIN_OPEN : (pin_hi_s[2] ? PIN_HIGH : PIN_LOW);
		idx = 5'(c2 * PIN_STATES * PIN_STATES + c1 * PIN_STATES + c0);
		own_addr_nxt = {ADDR_FIXED_MSB, addr_low_bits(idx)};
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			own_addr_r <= {ADDR_FIXED_MSB, 5'h00};
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
			own_addr_r <= own_addr_nxt;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	assign scl_rise = scl_s && !scl_d_r;
	assign scl_fall = !scl_s && scl_d_r;
	assign start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
	assign stop_det = scl_s && scl_d_r && !sda_d_r && sda_s;

	bus_state_t state_r, state_nxt;
	byte_kind_t kind_r, kind_nxt;
	logic rw_r, rw_nxt;
	logic ara_r, ara_nxt;
	logic full_r, full_nxt;
	logic mack_r, mack_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic oe_r, oe_nxt;
	logic [PTR_W-1:0] ptr_r, ptr_nxt;
	logic wr_stb_r, wr_stb_nxt;
	logic [7:0] wr_data_r, wr_data_nxt;
	logic rel_alert;
	logic alert_r;

	logic hit_own;
	logic hit_bc;
	logic hit_ara;
	assign hit_own = shift_r[7:1] == own_addr_r;
	assign hit_bc = shift_r[7:1] == BCAST_ADDR && !shift_r[0] &&
		i_broadcast_write_enable_bit;
	assign hit_ara = shift_r[7:1] == ALERT_RESP_ADDR && shift_r[0] &&
		alert_r;

	always_comb begin
		state_nxt = state_r;
		kind_nxt = kind_r;
		rw_nxt = rw_r;
		ara_nxt = ara_r;
		full_nxt = full_r;
		mack_nxt = mack_r;
		cnt_nxt = cnt_r;
		shift_nxt = shift_r;
		oe_nxt = oe_r;
		ptr_nxt = ptr_r;
		wr_stb_nxt = 1'b0;
		wr_data_nxt = wr_data_r;
		rel_alert = 1'b0;
		if (start_det) begin
			state_nxt = ST_RX;
			kind_nxt = K_ADDR;
			cnt_nxt = BIT_FIRST;
			full_nxt = 1'b0;
			oe_nxt = 1'b0;
		end else if (stop_det) begin
			state_nxt = ST_IDLE;
			oe_nxt = 1'b0;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					oe_nxt = 1'b0;
				end
				ST_RX: begin
					if (scl_rise) begin
						shift_nxt = {shift_r[6:0], sda_s};
						cnt_nxt = cnt_r + 3'h1;
						full_nxt = cnt_r == BIT_LAST;
					end else if (scl_fall && full_r) begin
						full_nxt = 1'b0;
						if (kind_r == K_ADDR) begin
							rw_nxt = shift_r[0];
							ara_nxt = hit_ara;
							if (hit_own || hit_bc || hit_ara) begin
								oe_nxt = 1'b1;
								state_nxt = ST_ACK;
								rel_alert = hit_own;
							end else begin
								state_nxt = ST_IDLE;
							end
						end else begin
							oe_nxt = 1'b1;
							state_nxt = ST_ACK;
							if (kind_r == K_DATA) begin
								wr_data_nxt = shift_r;
							end
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						oe_nxt = 1'b0;
						cnt_nxt = BIT_FIRST;
						state_nxt = ST_RX;
						unique case (kind_r)
							K_ADDR: begin
								if (rw_r) begin
									// The register byte is taken as the first bit goes out.
									shift_nxt = ara_r ? {own_addr_r, 1'b0} :
										i_reg_rd_data;
									oe_nxt = !shift_nxt[7];
									state_nxt = ST_TX;
								end else begin
									kind_nxt = K_CMD;
								end
							end
							K_CMD: begin
								ptr_nxt = shift_r[PTR_W-1:0];
								kind_nxt = K_DATA;
							end
							K_DATA: begin
								wr_stb_nxt = 1'b1;
								kind_nxt = K_EXTRA;
							end
							K_EXTRA: begin
								kind_nxt = K_EXTRA;
							end
						endcase
					end
				end
				ST_TX: begin
					if (scl_rise && ara_r && !oe_r && !sda_s) begin
						// A lower address pulled the line low: drop out.
						state_nxt = ST_IDLE;
					end else if (scl_fall) begin
						cnt_nxt = cnt_r + 3'h1;
						if (cnt_r == BIT_LAST) begin
							oe_nxt = 1'b0;
							state_nxt = ST_MACK;
							rel_alert = ara_r;
						end else begin
							shift_nxt = {shift_r[6:0], 1'b0};
							oe_nxt = !shift_r[6];
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						mack_nxt = !sda_s;
					end else if (scl_fall) begin
						cnt_nxt = BIT_FIRST;
						if (mack_r && !ara_r) begin
							shift_nxt = i_reg_rd_data;
							oe_nxt = !i_reg_rd_data[7];
							state_nxt = ST_TX;
						end else begin
							state_nxt = ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			state_r <= ST_IDLE;
			kind_r <= K_ADDR;
			rw_r <= 1'b0;
			ara_r <= 1'b0;
			full_r <= 1'b0;
			mack_r <= 1'b0;
			cnt_r <= BIT_FIRST;
			shift_r <= 8'h00;
			oe_r <= 1'b0;
			ptr_r <= PTR_RESET;
			wr_stb_r <= 1'b0;
			wr_data_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			kind_r <= kind_nxt;
			rw_r <= rw_nxt;
			ara_r <= ara_nxt;
			full_r <= full_nxt;
			mack_r <= mack_nxt;
			cnt_r <= cnt_nxt;
			shift_r <= shift_nxt;
			oe_r <= oe_nxt;
			ptr_r <= ptr_nxt;
			wr_stb_r <= wr_stb_nxt;
			wr_data_r <= wr_data_nxt;
		end
	end

	logic [N_FAULT-1:0] served_r, served_nxt;
	logic [N_FAULT-1:0] active;
	logic alert_nxt;

	// A bit stays served until its fault clears, so a steady fault
	// cannot raise the line again.
	always_comb begin
		active = i_fault_log & i_alert_enable;
		served_nxt = (served_r | (rel_alert ? active : '0)) & i_fault_log;
		alert_nxt = alert_r;
		if (rel_alert) begin
			alert_nxt = 1'b0;
		end else if (|(active & ~served_r)) begin
			alert_nxt = 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			served_r <= '0;
			alert_r <= 1'b0;
		end else begin
			served_r <= served_nxt;
			alert_r <= alert_nxt;
		end
	end

	assign o_serial_data_out_line = 1'b0;
	assign o_serial_data_out_line_oe = oe_r;
	assign o_alert_out = 1'b0;
	assign o_alert_oe = alert_r;
	assign o_reg_ptr = ptr_r;
	assign o_reg_wr_stb = wr_stb_r;
	assign o_reg_wr_data = wr_data_r;

endmodule : smbus_slave_alert

/* test/smbus_slave_alert_asserts.sv */
`timescale 1ns/1ps
module smbus_slave_alert_asserts
	import smbus_alert_pkg::*;
#(
	parameter int N_FAULT = 8
) (
	// Clock, reset and bus clock
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_scl,
	// Outputs and fault state
	input wire logic o_serial_data_out_line,
	input wire logic o_serial_data_out_line_oe,
	input wire logic o_alert_out,
	input wire logic o_alert_oe,
	input wire logic [N_FAULT-1:0] i_fault_log,
	input wire logic [N_FAULT-1:0] i_alert_enable,
	input wire logic [PTR_W-1:0] o_reg_ptr,
	input wire logic o_reg_wr_stb
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);
	logic oe;
	logic [N_FAULT-1:0] fe;
	assign oe = o_serial_data_out_line_oe;
	assign fe = i_fault_log & i_alert_enable;
	// The pointer and the strobe may only follow an ack that we drove.
	sequence s_acked;
		$past(oe) || $past(oe, 2) || $past(oe, 3) || $past(oe, 4);
	endsequence
	chk_drive_low_only: assert property (
		!o_serial_data_out_line && !o_alert_out) else $error("pin value");
	chk_strobe_single: assert property (
		o_reg_wr_stb |=> !o_reg_wr_stb) else $error("long strobe");
	chk_strobe_acked: assert property (
		$rose(o_reg_wr_stb) |-> s_acked) else $error("strobe w/o ack");
	chk_ptr_acked: assert property (
		$changed(o_reg_ptr) |-> s_acked) else $error("ptr w/o ack");
	chk_alert_cause: assert property (
		$rose(o_alert_oe) |-> |$past(fe)) else $error("alert w/o fault");
	chk_alert_new: assert property (
		$rose(o_alert_oe) |-> |($past(fe) & ~$past(fe, 2)))
		else $error("alert repeated");
	chk_alert_release: assert property (
		$fell(o_alert_oe) |-> ##[0:3] (oe != $past(oe, 6)))
		else $error("alert release off bus");
	chk_data_scl_high: assert property (
		i_scl && $past(i_scl) |-> $stable(oe)) else $error("data moved");
endmodule : smbus_slave_alert_asserts

bind smbus_slave_alert smbus_slave_alert_asserts #(.N_FAULT(N_FAULT))
	i_smbus_slave_alert_asserts (.i_clk_sys, .i_nrst, .i_scl,
	.o_serial_data_out_line, .o_serial_data_out_line_oe, .o_alert_out,
	.o_alert_oe, .i_fault_log, .i_alert_enable, .o_reg_ptr, .o_reg_wr_stb);

/* test/smbus_master_model.sv */
`timescale 1ns/1ps
module smbus_master_model (
	// Clock
	input wire logic i_clk_sys,
	// Bus wires
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	// The bus clock stands high between frames.
	initial begin
		o_scl = 1'h1;
		o_sda = 1'h1;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask : cyc
	// Data moves mid-way through the low phase, clear of both edges.
	task automatic put_bit(input logic b, output logic r);
		cyc(2);
		o_sda = b;
		cyc(3);
		o_scl = 1'h1;
		cyc(5);
		r = i_sda;
		o_scl = 1'h0;
	endtask : put_bit
	task automatic start();
		cyc(2);
		o_sda = 1'h1;
		cyc(3);
		o_scl = 1'h1;
		cyc(5);
		o_sda = 1'h0;
		cyc(5);
		o_scl = 1'h0;
	endtask : start
	task automatic stop();
		cyc(2);
		o_sda = 1'h0;
		cyc(3);
		o_scl = 1'h1;
		cyc(5);
		o_sda = 1'h1;
		cyc(5);
	endtask : stop
	task automatic send(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) put_bit(d[i], r);
		put_bit(1'h1, r);
		ack = !r;
	endtask : send
	// A zero in drv pulls the line as a rival responder would.
	task automatic recv(input logic [7:0] drv, input logic mack,
		output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) put_bit(drv[i], d[i]);
		put_bit(!mack, r);
	endtask : recv
endmodule : smbus_master_model

/* test/smbus_slave_alert_interface_test.sv */
`timescale 1ns/1ps
module smbus_slave_alert_interface_test import smbus_alert_pkg::*;;
	logic clk, nrst, bwe, stb, oe, sd, aoe, ao, m_scl, m_sda, ack;
	logic [2:0] p_hi, p_open, ptr;
	logic [7:0] flt, aen, rd_base, wdata, d, cmd;
	logic [7:0] rd_data;
	logic [31:0] rng;
	logic [6:0] own;
	wire sda;
	int err_count = 0;
	int n_tests = 0;
	int n_stb = 0;
	logic [4:0] tbl [27] = '{5'h04, 5'h07, 5'h06, 5'h18, 5'h05, 5'h01, 5'h00,
		5'h03, 5'h02, 5'h14, 5'h17, 5'h16, 5'h1a, 5'h15, 5'h11, 5'h10, 5'h13,
		5'h12, 5'h0c, 5'h0f, 5'h0e, 5'h19, 5'h0d, 5'h09, 5'h08, 5'h0b, 5'h0a};
	assign sda = m_sda & !oe;
	// Each register reads back differently, so a wrong pointer shows.
	assign rd_data = {rd_base[7:3], rd_base[2:0] ^ ptr};
	smbus_slave_alert i_smbus_slave_alert (.i_clk_sys(clk), .i_nrst(nrst),
		.i_scl(m_scl), .i_serial_data_in_line(sda),
		.o_serial_data_out_line(sd), .o_serial_data_out_line_oe(oe),
		.o_alert_out(ao), .o_alert_oe(aoe), .i_addr_select_pins_high(p_hi),
		.i_addr_select_pins_open(p_open), .i_broadcast_write_enable_bit(bwe),
		.i_fault_log(flt), .i_alert_enable(aen), .o_reg_ptr(ptr),
		.i_reg_rd_data(rd_data), .o_reg_wr_stb(stb),
		.o_reg_wr_data(wdata));
	smbus_master_model i_smbus_master_model (.i_clk_sys(clk), .i_sda(sda),
		.o_scl(m_scl), .o_sda(m_sda));
	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) n_stb <= n_stb + (stb === 1'h1);
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction : xs
	task automatic chk(input logic [7:0] s, input logic [7:0] e, string nm);
		n_tests++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s exp %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic test_done();
		$display("checks %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : test_done
	task automatic hdr(input logic [6:0] a, input logic rw, output logic k);
		i_smbus_master_model.start();
		i_smbus_master_model.send({a, rw}, k);
	endtask : hdr
	task automatic snd(input logic [7:0] b);
		i_smbus_master_model.send(b, ack);
	endtask : snd
	task automatic rcv(input logic [7:0] drv, input logic mack);
		i_smbus_master_model.recv(drv, mack, d);
	endtask : rcv
	task automatic sp();
		i_smbus_master_model.stop();
	endtask : sp
	task automatic pins(input int i);
		p_open = {i / 9 == 2, i / 3 % 3 == 2, i % 3 == 2};
		p_hi = {i / 9 == 1, i / 3 % 3 == 1, i % 3 == 1};
		own = {ADDR_FIXED_MSB, tbl[i]};
		i_smbus_master_model.cyc(5);
	endtask : pins
	// Whole run is about 9k cycles; the margin covers slow acks.
	initial begin
		#400000;
		err_count++;
		test_done();
	end
	initial begin
		{nrst, p_hi, p_open, flt, aen, rd_base} = '0;
		bwe = 1'h1;
		rng = 32'h6ee4;
		repeat (8) @(posedge clk);
		#1 nrst = 1'h1;
		for (int i = 0; i < 27; i++) begin
			pins(i);
			hdr(own, 1'h0, ack);
			chk(ack, 8'h01, "addr");
			sp();
			hdr(own ^ 7'h01, 1'h0, ack);
			chk(ack, 8'h00, "miss");
			sp();
		end
		rng = xs(rng);
		pins(rng % 27);
		for (int w = 0; w < 2; w++) begin
			int s;
			s = n_stb;
			rng = xs(rng);
			{d, cmd} = rng[15:0];
			hdr(own, 1'h0, ack);
			snd(cmd);
			chk(ack, 8'h01, "cmd ack");
			snd(d);
			chk(ack, 8'h01, "data ack");
			if (w == 1) snd(~d);
			chk(ack, 8'h01, "word ack");
			sp();
			chk(ptr, cmd[2:0], "ptr");
			chk(wdata, d, "wdata");
			chk(8'(n_stb - s), 8'h01, "strobes");
		end
		rng = xs(rng);
		{rd_base, cmd} = rng[15:0];
		hdr(own, 1'h0, ack);
		snd(cmd);
		hdr(own, 1'h1, ack);
		chk(ack, 8'h01, "rd ack");
		rcv(8'hff, 1'h1);
		chk(d, rd_base ^ {5'h00, cmd[2:0]}, "rd 1");
		rcv(8'hff, 1'h0);
		chk(d, rd_base ^ {5'h00, cmd[2:0]}, "rd 2");
		sp();
		hdr(own, 1'h1, ack);
		rcv(8'hff, 1'h0);
		sp();
		chk(d, rd_base ^ {5'h00, cmd[2:0]}, "rcv");
		for (int e = 0; e < 2; e++) begin
			bwe = e[0];
			hdr(BCAST_ADDR, 1'h0, ack);
			sp();
			chk(ack, 8'(e), "bcast w");
		end
		hdr(BCAST_ADDR, 1'h1, ack);
		sp();
		chk(ack, 8'h00, "bcast r");
		rng = xs(rng);
		aen = (rng[7:0] | 8'h05) & 8'hfd;
		hdr(ALERT_RESP_ADDR, 1'h1, ack);
		sp();
		chk(ack, 8'h00, "ara idle");
		flt = 8'h02;
		i_smbus_master_model.cyc(3);
		chk(aoe, 8'h00, "masked");
		flt = 8'h03;
		i_smbus_master_model.cyc(2);
		chk(aoe, 8'h01, "alert");
		hdr(ALERT_RESP_ADDR, 1'h1, ack);
		chk(ack, 8'h01, "ara ack");
		rcv(8'h7f, 1'h0);
		sp();
		chk(aoe, 8'h01, "loser");
		hdr(ALERT_RESP_ADDR, 1'h1, ack);
		rcv(8'hff, 1'h0);
		sp();
		chk(d, {own, 1'h0}, "ara addr");
		chk(aoe, 8'h00, "winner");
		flt = 8'h07;
		i_smbus_master_model.cyc(2);
		chk(aoe, 8'h01, "new fault");
		hdr(own, 1'h0, ack);
		sp();
		chk(aoe, 8'h00, "addressed");
		flt = 8'h00;
		i_smbus_master_model.cyc(2);
		flt = 8'h01;
		i_smbus_master_model.cyc(2);
		chk(aoe, 8'h01, "recur");
		chk(8'({sd, ao}), 8'h00, "pin value");
		test_done();
	end
endmodule : smbus_slave_alert_interface_test
